// ==== src/frsyn_map.svh ====
// register offsets, field positions, reset values and timing counts of the synthesizer block
`ifndef FRSYN_MAP_SVH
`define FRSYN_MAP_SVH

`define FRSYN_OFF_PROG        12'h000
`define FRSYN_OFF_STATUS      12'h004
`define FRSYN_OFF_MODULUS     12'h008
`define FRSYN_OFF_TIMER       12'h00c
`define FRSYN_OFF_DIVIDERS    12'h010

`define FRSYN_CTL_LO          0
`define FRSYN_CTL_HI          1
`define FRSYN_SEL_FEEDBACK    2'h0
`define FRSYN_SEL_REFERENCE   2'h1
`define FRSYN_SEL_CONTROL     2'h2
`define FRSYN_SEL_NOISE       2'h3

`define FRSYN_FB_FASTLOCK     23
`define FRSYN_FB_INT_HI       22
`define FRSYN_FB_INT_LO       14
`define FRSYN_FB_FRACTIONAL_VALUE_HI      13
`define FRSYN_FB_FRACTIONAL_VALUE_LO      2

`define FRSYN_RD_LOAD_SELECT  23
`define FRSYN_RD_MUX_HI       22
`define FRSYN_RD_MUX_LO       20
`define FRSYN_RD_PRESCALER    18
`define FRSYN_RD_RDIV_HI      17
`define FRSYN_RD_RDIV_LO      14
`define FRSYN_RD_MOD_HI       13
`define FRSYN_RD_MOD_LO       2

`define FRSYN_CW_COUNTER_HOLD 2

`define FRSYN_RST_WORD        24'h000000
`define FRSYN_RST_MODULUS     12'h001
`define FRSYN_RST_RDIV        4'h1

`define FRSYN_CP_FAST_GAIN    5'h10
`define FRSYN_CP_SLOW_GAIN    5'h01

`define FRSYN_LOCK_CYCLES     40
`define FRSYN_LOCK_ERR_NS     15
`define FRSYN_UNLOCK_ERR_NS   30

`endif

// ==== src/frsyn_pkg.sv ====
// types shared by the synthesizer programming block
package frsyn_pkg;

  typedef logic [23:0] frsyn_word_t;

  typedef enum logic [2:0] {
    FRSYN_MUX_LOW,
    FRSYN_MUX_LOCK,
    FRSYN_MUX_COMPARE,
    FRSYN_MUX_FASTLOCK,
    FRSYN_MUX_REFERENCE,
    FRSYN_MUX_HOLD,
    FRSYN_MUX_CPGAIN,
    FRSYN_MUX_HIGH
  } frsyn_mux_sel_t;

  typedef enum logic {
    FRSYN_HUNT,
    FRSYN_LOCKED
  } frsyn_lock_state_t;

endpackage

// ==== src/frsyn_lock_detect.sv ====
// digital lock detector counting good comparison cycles
`timescale 1ns/100ps
`include "frsyn_map.svh"

module frsyn_lock_detect #(
  parameter int LOCK_CYCLES = `FRSYN_LOCK_CYCLES,
  parameter int ERR_W       = 8
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             restart,
  input  wire logic             compare_tick,
  input  wire logic [ERR_W-1:0] phase_err_ns,
  output logic                  locked
);
  import frsyn_pkg::*;

  localparam logic [ERR_W-1:0] LOCK_ERR   = ERR_W'(`FRSYN_LOCK_ERR_NS);
  localparam logic [ERR_W-1:0] UNLOCK_ERR = ERR_W'(`FRSYN_UNLOCK_ERR_NS);
  localparam logic [6:0]       LOCK_LAST  = 7'(LOCK_CYCLES - 1);

  frsyn_lock_state_t state_reg;
  logic [6:0]        good_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= FRSYN_HUNT;
      good_reg  <= 7'h00;
    end else if (restart) begin
      state_reg <= FRSYN_HUNT;
      good_reg  <= 7'h00;
    end else if (compare_tick) begin
      case (state_reg)
        FRSYN_HUNT: begin
          if (phase_err_ns >= LOCK_ERR) begin
            good_reg <= 7'h00;
          end else if (good_reg == LOCK_LAST) begin
            state_reg <= FRSYN_LOCKED;
            good_reg  <= 7'h00;
          end else begin
            good_reg <= good_reg + 7'h01;
          end
        end
        FRSYN_LOCKED: begin
          if (phase_err_ns > UNLOCK_ERR) begin
            state_reg <= FRSYN_HUNT;
          end
        end
        default: begin
          state_reg <= FRSYN_HUNT;
          good_reg  <= 7'h00;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      locked <= 1'b0;
    end else begin
      locked <= (state_reg == FRSYN_LOCKED) && !restart;
    end
  end

endmodule

// ==== src/frsyn_program_regs.sv ====
// programming registers, fast-lock timer, reference divider and status of the fractional synthesizer
`timescale 1ns/100ps
`include "frsyn_map.svh"

module frsyn_program_regs #(
  parameter int ERR_W = 8
) (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic                  reference_tick,
  input  wire logic [ERR_W-1:0]      phase_err_ns,
  output logic      [8:0]            int_value,
  output logic      [11:0]           fractional_value,
  output logic      [11:0]           modulus_value,
  output logic                       prescaler_high,
  output frsyn_pkg::frsyn_mux_sel_t  status_select,
  output frsyn_pkg::frsyn_word_t     control_word,
  output frsyn_pkg::frsyn_word_t     noise_spur_word,
  output logic      [4:0]            cp_gain,
  output logic                       compare_tick,
  output logic                       lock_detect,
  output logic                       muxed_status_output
);
  import frsyn_pkg::*;

  function automatic logic [11:0] mid_field(input frsyn_word_t w);
    mid_field = w[`FRSYN_RD_MOD_HI:`FRSYN_RD_MOD_LO];
  endfunction

  logic        setup_hit;
  logic        wr_now;
  logic        rd_now;
  logic [1:0]  sel;
  frsyn_word_t word;
  logic        wr_feedback;
  logic        wr_reference;
  logic        wr_control;
  logic        wr_noise;
  logic        counter_hold;
  logic        mapped;

  assign setup_hit    = psel && penable && !pready;
  assign mapped       = (paddr == `FRSYN_OFF_PROG) || (paddr == `FRSYN_OFF_STATUS) ||
                        (paddr == `FRSYN_OFF_MODULUS) || (paddr == `FRSYN_OFF_TIMER) ||
                        (paddr == `FRSYN_OFF_DIVIDERS);
  assign wr_now       = setup_hit && pwrite && (paddr == `FRSYN_OFF_PROG);
  assign rd_now       = setup_hit && !pwrite;
  assign word         = pwdata[23:0];
  assign sel          = word[`FRSYN_CTL_HI:`FRSYN_CTL_LO];
  assign wr_feedback  = wr_now && (sel == `FRSYN_SEL_FEEDBACK);
  assign wr_reference = wr_now && (sel == `FRSYN_SEL_REFERENCE);
  assign wr_control   = wr_now && (sel == `FRSYN_SEL_CONTROL);
  assign wr_noise     = wr_now && (sel == `FRSYN_SEL_NOISE);
  assign counter_hold = control_word[`FRSYN_CW_COUNTER_HOLD];

  frsyn_word_t last_word_reg;
  logic [11:0] mod_pending_reg;
  logic [11:0] timer_value_reg;
  logic [3:0]  ref_div_reg;
  logic [3:0]  ref_count_reg;
  logic [11:0] timer_count_reg;
  logic        fast_active_reg;
  logic        fast_start;
  logic        lock_raw;

  // answer one cycle into the access phase; writes land on that same edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup_hit;
      pslverr <= setup_hit && !mapped;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (rd_now) begin
      case (paddr)
        `FRSYN_OFF_PROG:     prdata <= {8'h00, last_word_reg};
        `FRSYN_OFF_STATUS:   prdata <= {24'h000000, cp_gain, fast_active_reg, counter_hold, lock_detect};
        `FRSYN_OFF_MODULUS:  prdata <= {4'h0, mod_pending_reg, 4'h0, modulus_value};
        `FRSYN_OFF_TIMER:    prdata <= {4'h0, timer_value_reg, 4'h0, timer_count_reg};
        `FRSYN_OFF_DIVIDERS: prdata <= {7'h00, int_value, fractional_value, ref_div_reg};
        default:             prdata <= 32'h00000000;
      endcase
    end else begin
      prdata <= 32'h00000000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_word_reg <= `FRSYN_RST_WORD;
    end else if (wr_now) begin
      last_word_reg <= word;
    end
  end

  // only the word picked by its control bits changes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_value        <= 9'h000;
      fractional_value <= 12'h000;
    end else if (wr_feedback) begin
      int_value        <= word[`FRSYN_FB_INT_HI:`FRSYN_FB_INT_LO];
      fractional_value <= word[`FRSYN_FB_FRACTIONAL_VALUE_HI:`FRSYN_FB_FRACTIONAL_VALUE_LO];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prescaler_high <= 1'b0;
      status_select  <= FRSYN_MUX_LOW;
      ref_div_reg    <= `FRSYN_RST_RDIV;
    end else if (wr_reference) begin
      prescaler_high <= word[`FRSYN_RD_PRESCALER];
      status_select  <= frsyn_mux_sel_t'(word[`FRSYN_RD_MUX_HI:`FRSYN_RD_MUX_LO]);
      ref_div_reg    <= word[`FRSYN_RD_RDIV_HI:`FRSYN_RD_RDIV_LO];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mod_pending_reg <= `FRSYN_RST_MODULUS;
      timer_value_reg <= 12'h000;
    end else if (wr_reference) begin
      if (word[`FRSYN_RD_LOAD_SELECT]) begin
        timer_value_reg <= mid_field(word);
      end else begin
        mod_pending_reg <= mid_field(word);
      end
    end
  end

  // pending modulus goes live only on the next feedback write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      modulus_value <= `FRSYN_RST_MODULUS;
    end else if (wr_feedback) begin
      modulus_value <= mod_pending_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_word <= `FRSYN_RST_WORD;
    end else if (wr_control) begin
      control_word <= word;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      noise_spur_word <= `FRSYN_RST_WORD;
    end else if (wr_noise) begin
      noise_spur_word <= word;
    end
  end

  // a ratio of 0 is not legal; treated as 1 so the comparison clock never stops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_count_reg <= 4'h0;
      compare_tick  <= 1'b0;
    end else if (counter_hold) begin
      ref_count_reg <= 4'h0;
      compare_tick  <= 1'b0;
    end else if (reference_tick) begin
      if (ref_count_reg + 4'h1 >= ref_div_reg) begin
        ref_count_reg <= 4'h0;
        compare_tick  <= 1'b1;
      end else begin
        ref_count_reg <= ref_count_reg + 4'h1;
        compare_tick  <= 1'b0;
      end
    end else begin
      compare_tick <= 1'b0;
    end
  end

  assign fast_start = wr_feedback && word[`FRSYN_FB_FASTLOCK] && (timer_value_reg != 12'h000);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_count_reg <= 12'h000;
      fast_active_reg <= 1'b0;
    end else if (counter_hold) begin
      timer_count_reg <= 12'h000;
      fast_active_reg <= 1'b0;
    end else if (fast_start) begin
      timer_count_reg <= timer_value_reg;
      fast_active_reg <= 1'b1;
    end else if (fast_active_reg && compare_tick) begin
      timer_count_reg <= timer_count_reg - 12'h001;
      if (timer_count_reg == 12'h001) begin
        fast_active_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cp_gain <= `FRSYN_CP_SLOW_GAIN;
    end else begin
      cp_gain <= fast_active_reg ? `FRSYN_CP_FAST_GAIN : `FRSYN_CP_SLOW_GAIN;
    end
  end

  frsyn_lock_detect #(
    .LOCK_CYCLES (`FRSYN_LOCK_CYCLES),
    .ERR_W       (ERR_W)
  ) u_lock (
    .pclk         (pclk),
    .presetn      (presetn),
    .restart      (wr_feedback || counter_hold),
    .compare_tick (compare_tick),
    .phase_err_ns (phase_err_ns),
    .locked       (lock_raw)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_detect <= 1'b0;
    end else begin
      lock_detect <= lock_raw && !wr_feedback;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      muxed_status_output <= 1'b0;
    end else begin
      case (status_select)
        FRSYN_MUX_LOW:       muxed_status_output <= 1'b0;
        FRSYN_MUX_LOCK:      muxed_status_output <= lock_raw;
        FRSYN_MUX_COMPARE:   muxed_status_output <= compare_tick;
        FRSYN_MUX_FASTLOCK:  muxed_status_output <= fast_active_reg;
        FRSYN_MUX_REFERENCE: muxed_status_output <= reference_tick;
        FRSYN_MUX_HOLD:      muxed_status_output <= counter_hold;
        FRSYN_MUX_CPGAIN:    muxed_status_output <= (cp_gain == `FRSYN_CP_FAST_GAIN);
        FRSYN_MUX_HIGH:      muxed_status_output <= 1'b1;
        default:             muxed_status_output <= 1'b0;
      endcase
    end
  end

endmodule

// ==== sim/frsyn_program_regs_props.sv ====
// port checks of the synthesizer programming block
`timescale 1ns/100ps
module frsyn_program_regs_props #(
  parameter int ERR_W = 8
) (
  input wire logic                      pclk,
  input wire logic                      presetn,
  input wire logic                      psel,
  input wire logic                      penable,
  input wire logic                      pwrite,
  input wire logic                      pready,
  input wire logic [11:0]               paddr,
  input wire logic [31:0]               pwdata,
  input wire logic [8:0]                int_value,
  input wire logic [11:0]               modulus_value,
  input wire frsyn_pkg::frsyn_mux_sel_t status_select,
  input wire logic [4:0]                cp_gain,
  input wire logic                      reference_tick,
  input wire logic                      compare_tick,
  input wire logic                      lock_detect,
  input wire logic [ERR_W-1:0]          phase_err_ns
);
  import frsyn_pkg::*;
  // word is taken in the first access cycle
  wire take = psel & penable & pwrite & !pready & (paddr == 12'h000);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_int_load: assert property (take && pwdata[1:0] == 2'h0 |=> int_value == $past(pwdata[22:14]))
    else $error("int field not loaded");
  chk_mod_buffer: assert property (take && pwdata[1:0] == 2'h1 |=> $stable(modulus_value))
    else $error("modulus changed on reference write");
  chk_mux_select: assert property (take && pwdata[1:0] == 2'h1 |=> status_select == $past(pwdata[22:20]))
    else $error("status select not loaded");
  chk_gain_levels: assert property (cp_gain == 5'h10 || cp_gain == 5'h01)
    else $error("pump gain not 16 or 1");
  chk_tick_cause: assert property (compare_tick |-> $past(reference_tick))
    else $error("compare tick without reference tick");
  // state, raw lock and output flop each add one edge after the last good tick
  chk_lock_rise: assert property ($rose(lock_detect) |-> $past(compare_tick, 3) && $past(phase_err_ns, 3) < 15)
    else $error("lock rose without good tick");
  chk_lock_drop: assert property (compare_tick && phase_err_ns > 30 |-> ##3 !lock_detect)
    else $error("lock kept after large error");
  chk_new_chan: assert property (take && pwdata[1:0] == 2'h0 |=> !lock_detect)
    else $error("lock kept after new channel");
endmodule

bind frsyn_program_regs frsyn_program_regs_props #(.ERR_W(ERR_W)) i_frsyn_program_regs_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready),
  .paddr(paddr), .pwdata(pwdata), .int_value(int_value), .modulus_value(modulus_value),
  .status_select(status_select), .cp_gain(cp_gain), .reference_tick(reference_tick),
  .compare_tick(compare_tick), .lock_detect(lock_detect), .phase_err_ns(phase_err_ns));

// ==== sim/frsyn_ref_source.sv ====
// reference edge and phase error source for the synthesizer block
`timescale 1ns/100ps
module frsyn_ref_source #(
  parameter int ERR_W = 8
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             err_bad,
  output logic                  reference_tick,
  output logic      [ERR_W-1:0] phase_err_ns
);
  logic [1:0] div_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg <= 2'h0;
      reference_tick <= 1'b0;
    end else begin
      div_reg <= (div_reg == 2'h2) ? 2'h0 : div_reg + 2'h1;
      reference_tick <= (div_reg == 2'h2);
    end
  end
  // error changes every cycle so a stale sample shows up
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      phase_err_ns <= '0;
    else
      phase_err_ns <= err_bad ? ERR_W'(31 + $urandom % 60) : ERR_W'($urandom % 15);
  end
endmodule

// ==== sim/frsyn_program_regs_tb_top.sv ====
// self-checking bench of the synthesizer programming registers
`timescale 1ns/100ps
module frsyn_program_regs_tb_top;
  import frsyn_pkg::*;
  logic                 pclk, presetn, psel, penable, pwrite, pready, pslverr, err_bad, perr;
  logic          [11:0] paddr, fractional_value, modulus_value, m;
  logic          [31:0] pwdata, prdata, rd;
  logic           [8:0] int_value, iv;
  logic           [7:0] phase_err_ns;
  logic           [4:0] cp_gain;
  logic           [3:0] r;
  logic                 prescaler_high, compare_tick, lock_detect, muxed_status_output, reference_tick;
  frsyn_mux_sel_t       status_select;
  frsyn_word_t          control_word, noise_spur_word;
  int                   fail_count, n_checks, cyc, n, k;

  frsyn_program_regs #(.ERR_W(8)) i_frsyn_program_regs (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .reference_tick(reference_tick), .phase_err_ns(phase_err_ns), .int_value(int_value),
    .fractional_value(fractional_value), .modulus_value(modulus_value), .prescaler_high(prescaler_high),
    .status_select(status_select), .control_word(control_word), .noise_spur_word(noise_spur_word),
    .cp_gain(cp_gain), .compare_tick(compare_tick), .lock_detect(lock_detect),
    .muxed_status_output(muxed_status_output));
  frsyn_ref_source #(.ERR_W(8)) i_frsyn_ref_source (.pclk(pclk), .presetn(presetn), .err_bad(err_bad),
    .reference_tick(reference_tick), .phase_err_ns(phase_err_ns));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  function automatic logic [31:0] fbw(input logic fl, input logic [8:0] i, input logic [11:0] f);
    return {8'h00, fl, i, f, 2'h0};
  endfunction
  function automatic logic [31:0] rdw(input logic ld, input logic [2:0] mx, input logic pr, input logic [3:0] rv,
                                      input logic [11:0] md);
    return {8'h00, ld, mx, 1'b0, pr, rv, md, 2'h1};
  endfunction

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int t = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      t++;
    end while (pready !== 1'b1 && t < 20);
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (t >= 20) begin
      fail_count++;
      conclude();
    end
  endtask
  task automatic ticks(input int t);
    int g = 0;
    while (t > 0 && g < 3000) begin
      @(posedge pclk);
      g++;
      if (compare_tick === 1'b1) t--;
    end
    if (t > 0) fail_count++;
  endtask

  // hang guard well above the run length
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      fail_count++;
      conclude();
    end
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    err_bad = 1'b0;
    n = $urandom(565);
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    m = 12'(100 + $urandom % 3900);
    apb(1'b1, 12'h000, rdw(1'b0, 3'h1, 1'b1, 4'h1, m));
    chk("held modulus", 32'h1, 32'(modulus_value));
    apb(1'b0, 12'h008, 32'h0);
    chk("pending modulus", 32'(m), 32'(rd[27:16]));
    iv = 9'(91 + $urandom % 400);
    apb(1'b1, 12'h000, fbw(1'b0, iv, m - 12'h1));
    repeat (2) @(posedge pclk);
    chk("active modulus", 32'(m), 32'(modulus_value));
    chk("fractional_value", 32'(m - 12'h1), 32'(fractional_value));
    apb(1'b0, 12'h010, 32'h0);
    chk("divider readback", {7'h0, iv, m - 12'h1, 4'h1}, rd);
    ticks(38);
    chk("early lock", 32'h0, 32'(lock_detect));
    ticks(4);
    repeat (3) @(posedge pclk);
    chk("lock", 32'h1, 32'(lock_detect));
    err_bad <= 1'b1;
    ticks(2);
    err_bad <= 1'b0;
    repeat (3) @(posedge pclk);
    chk("lock lost", 32'h0, 32'(lock_detect));
    ticks(45);
    chk("relock", 32'h1, 32'(lock_detect));
    apb(1'b1, 12'h000, fbw(1'b0, iv, 12'h0));
    chk("lock after new channel", 32'h0, 32'(lock_detect));
    apb(1'b1, 12'h000, rdw(1'b1, 3'h1, 1'b1, 4'h1, 12'h5));
    apb(1'b1, 12'h000, fbw(1'b1, iv, 12'h0));
    chk("modulus kept", 32'(m), 32'(modulus_value));
    n = 0;
    k = 0;
    // gain flop lags the timer by one edge: a tick counts if the gain is still high just after it
    repeat (41) begin
      if (k == 1 && cp_gain === 5'h10) n++;
      k = int'(compare_tick === 1'b1);
      @(posedge pclk);
    end
    chk("fast lock ticks", 32'h5, 32'(n));
    chk("gain back", 32'h1, 32'(cp_gain));
    for (k = 0; k < 8; k++) begin
      r = (k == 7) ? 4'hf : 4'(1 + $urandom % 15);
      apb(1'b1, 12'h000, rdw(1'b0, 3'(k), k[0], r, m));
      chk("mux select", 32'(k), 32'(status_select));
      chk("prescaler", 32'(k[0]), 32'(prescaler_high));
      ticks(2);
      if (k == 0 || k == 7) chk("mux output", 32'(k == 7), 32'(muxed_status_output));
      n = cyc;
      ticks(1);
      chk("compare period", 32'(3 * r), 32'(cyc - n));
    end
    n = $urandom;
    apb(1'b1, 12'h000, {8'h0, 22'(n), 2'h3});
    chk("noise word", {8'h0, 22'(n), 2'h3}, 32'(noise_spur_word));
    chk("int kept", 32'(iv), 32'(int_value));
    apb(1'b1, 12'h000, 32'h6);
    chk("control word", 32'h6, 32'(control_word));
    k = 0;
    repeat (30) @(posedge pclk) if (compare_tick === 1'b1) k++;
    chk("ticks in hold", 32'h0, 32'(k));
    apb(1'b1, 12'h000, 32'h2);
    apb(1'b0, 12'h020, 32'h0);
    chk("unmapped error", 32'h1, 32'(perr));
    chk("unmapped data", 32'h0, rd);
    conclude();
  end
endmodule
